/* File: hw/fbc_pkg.sv */
/*
  Shared constants and types for the burst flash command front end.
  Assumes a single 100 MHz system clock and a 16-bit word-addressed flash bus.
*/
`default_nettype none
package fbc_pkg;

  // Word address and data widths of the flash bus.
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int NBANK  = 4;
  localparam int SEC_W  = 7;

  // Command data values and the unlock addresses, low twelve address bits.
  localparam logic [7:0]  CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0]  CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0]  CMD_CONFIG  = 8'hC0;
  localparam logic [7:0]  CMD_QUERY   = 8'h90;
  localparam logic [7:0]  CMD_RESET   = 8'hF0;
  localparam logic [7:0]  CMD_SUSPEND = 8'hB0;
  localparam logic [7:0]  CMD_RESUME  = 8'h30;
  localparam logic [11:0] UNLOCK_ADDR1 = 12'h555;
  localparam logic [11:0] UNLOCK_ADDR2 = 12'h2AA;

  // Configuration code is taken from address bits 19 down to 12.
  localparam int CFG_LSB       = 12;
  localparam int CFG_MSB       = 19;
  localparam int CFG_ASYNC_BIT = 7;
  localparam int CFG_RDY_BIT   = 6;
  localparam int CFG_EDGE_BIT  = 5;
  localparam int CFG_LEN_LSB   = 3;
  localparam int CFG_WAIT_LSB  = 0;
  // Asynchronous, ready with data, rising edge, continuous, seven cycles.
  localparam logic [7:0] CFG_RESET = 8'hE5;

  // Initial access cycles are the wait code plus this base.
  localparam logic [3:0] WAIT_BASE = 4'h2;
  localparam logic [2:0] WAIT_MAX_CODE = 3'h5;

  // Sector geometry: boot sectors are 8K words, the rest 32K words.
  localparam logic [5:0] BIG_LOW_IDX  = 6'h00;
  localparam logic [5:0] BIG_HIGH_IDX = 6'h3F;
  localparam logic [6:0] HIGH_BOOT_BASE = 7'h42;
  localparam logic [6:0] BIG_SEC_OFS    = 7'h03;
  // First sector of the second, third and fourth bank.
  localparam logic [6:0] BANK1_FIRST = 7'h13;
  localparam logic [6:0] BANK2_FIRST = 7'h23;
  localparam logic [6:0] BANK3_FIRST = 7'h33;

  // Burst wrap masks for 8, 16 and 32 word modes.
  localparam logic [ADDR_W-1:0] WRAP_MASK8  = 21'h000007;
  localparam logic [ADDR_W-1:0] WRAP_MASK16 = 21'h00000F;
  localparam logic [ADDR_W-1:0] WRAP_MASK32 = 21'h00001F;
  localparam logic [ADDR_W-1:0] WRAP_MASKC  = 21'h1FFFFF;

  typedef enum logic [1:0] {
    FBC_LEN_CONT, FBC_LEN_W8, FBC_LEN_W16, FBC_LEN_W32
  } fbc_len_t;

  typedef enum logic [2:0] {
    FBC_CMD_IDLE, FBC_CMD_UNL1, FBC_CMD_UNL2, FBC_CMD_ERROR
  } fbc_cmd_t;

  typedef enum logic [2:0] {
    FBC_BANK_READ, FBC_BANK_BUSY, FBC_BANK_SUSP, FBC_BANK_SUSP_PROG, FBC_BANK_QUERY
  } fbc_bank_t;

  // Decoded burst configuration as seen by the read path.
  typedef struct packed {
    logic       async_mode;
    logic       rdy_with_data;
    logic       rising_edge;
    fbc_len_t   burst_len;
    logic [3:0] init_cycles;
  } fbc_cfg_t;

  // Whole state of the front end.
  typedef struct packed {
    logic [2:0]                     we_s;
    logic [2:0]                     avs_s;
    logic [ADDR_W-1:0]              addr_s1;
    logic [ADDR_W-1:0]              addr_s2;
    logic [DATA_W-1:0]              data_s1;
    logic [DATA_W-1:0]              data_s2;
    fbc_cmd_t                       cmd;
    fbc_bank_t [NBANK-1:0]          bank;
    logic [NBANK-1:0][SEC_W-1:0]    susp_sec;
    logic [7:0]                     cfg_code;
    logic                           cfg_set;
    logic [NBANK-1:0]               susp_req;
    logic [NBANK-1:0]               res_req;
    logic [3:0]                     cnt;
    logic                           bursting;
    logic                           rdy;
    logic                           dvalid;
    logic [ADDR_W-1:0]              bptr;
  } fbc_state_t;

endpackage
`default_nettype wire

/* File: hw/fbc_sector_decode.sv */
/*
  Combinational sector and bank decoder for a 16-bit word address.
  Assumes the address is already stable in the system clock domain.
*/
`default_nettype none
module fbc_sector_decode
  import fbc_pkg::*;
(
  input  wire logic [ADDR_W-1:0] word_addr,
  output logic      [SEC_W-1:0]  sector,
  output logic      [1:0]        bank
);

  logic [5:0] big_idx;

  // Each 32K-word slot is one sector except the two ends, split in four boot sectors.
  // sector decode
  always_comb begin
    big_idx = word_addr[20:15];
    if (big_idx == BIG_LOW_IDX) begin
      sector = {5'h00, word_addr[14:13]};
    end else if (big_idx == BIG_HIGH_IDX) begin
      sector = HIGH_BOOT_BASE + {5'h00, word_addr[14:13]};
    end else begin
      sector = {1'b0, big_idx} + BIG_SEC_OFS;
    end
  end

  // Banks hold 19, 16, 16 and 19 sectors from the bottom up.
  // bank mapping
  always_comb begin
    if (sector < BANK1_FIRST) begin
      bank = 2'h0;
    end else if (sector < BANK2_FIRST) begin
      bank = 2'h1;
    end else if (sector < BANK3_FIRST) begin
      bank = 2'h2;
    end else begin
      bank = 2'h3;
    end
  end

endmodule
`default_nettype wire

/* File: hw/fbc_cmd.sv */
/*
  Command front end of a four-bank burst flash: write-cycle decoder, bank read
  state tracking, burst configuration register and burst initial-access timing.
  Assumes the bus pins come from outside and are synchronised here, while the
  embedded algorithm engine sits on sys_clk and reports per-bank activity.
*/
`default_nettype none

// Function
// - Decode word addresses into 70 sectors, four 8K at each end.
// - Map 19, 16, 16 and 19 sectors onto the four banks.
// - A bad or out-of-order write sequence leaves an error state until reset.
// - After power-up every bank reads the array with no command.
// - A bank returns to array read when its algorithm finishes.
// - Erase suspend allows reads of all other sectors of that bank.
// - Burst is refused until the configuration register has been written.
// - Configuration load is two unlock cycles then C0h at 555h.
// - Third configuration cycle latches address bits 19 to 12.
// - Reset loads the default configuration, asynchronous reads.
// - Configuration is frozen while any program, erase or lock runs.
// - Bit 19 selects asynchronous when one, synchronous burst when zero.
// - Bits 14 to 12 count cycles from address strobe to data.
// - Initial access cycles equal the wait field plus two.
// - Reset selects seven initial access cycles.
// - With two initial cycles ready is aligned with valid data.
// - Bits 16 and 15 select continuous, 8, 16 or 32 word wrap.
// - Bit 17 selects rising edge when one, falling when zero.
// - Bit 18 puts ready with data when one, one cycle early when zero.
module fbc_cmd
  import fbc_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         arst_n,
  input  wire logic                         write_strobe_n,
  input  wire logic [ADDR_W-1:0]            addr_pin,
  input  wire logic [DATA_W-1:0]            data_pin,
  input  wire logic                         address_valid_strobe_n,
  input  wire logic [NBANK-1:0]             alg_busy,
  input  wire logic [NBANK-1:0]             alg_erasing,
  output fbc_bank_t [NBANK-1:0]             bank_mode,
  output logic      [NBANK-1:0]             suspend_req,
  output logic      [NBANK-1:0]             resume_req,
  output fbc_cfg_t                          burst_cfg,
  output logic                              burst_enable,
  output logic                              cmd_error,
  output logic                              read_allowed,
  output logic      [SEC_W-1:0]             read_sector,
  output logic      [1:0]                   read_bank,
  output logic      [ADDR_W-1:0]            burst_addr,
  output logic                              ready_out,
  output logic                              data_valid
);

  logic [1:0]       rst_sync_q;
  logic             rst_n;
  fbc_state_t       st_q;
  fbc_state_t       st_d;
  logic [SEC_W-1:0] sec;
  logic [1:0]       bnk;
  logic             wr_evt;
  logic             avs_evt;
  logic [7:0]       wdata;
  logic [11:0]      wlow;
  logic             any_busy;
  logic             cfg_ok;
  fbc_bank_t        cur_bank;
  logic [3:0]       load_cycles;
  logic             early_rdy;
  logic [ADDR_W-1:0] wmask;

  // Reset release passes two flops so every state flop leaves reset on the same edge.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // One decoder serves both the command address and the read address.
  fbc_sector_decode u_dec (
    .word_addr (st_q.addr_s2),
    .sector    (sec),
    .bank      (bnk)
  );

  // Events are taken from the second synchroniser stage and the stage after it.
  assign wr_evt   = st_q.we_s[1] & ~st_q.we_s[2];
  assign avs_evt  = ~st_q.avs_s[1] & st_q.avs_s[2];
  assign wdata    = st_q.data_s2[7:0];
  assign wlow     = st_q.addr_s2[11:0];
  assign any_busy = |alg_busy;
  assign cur_bank = st_q.bank[bnk];

  // Decoded configuration fields.
  // read mode select
  assign burst_cfg.async_mode    = st_q.cfg_code[CFG_ASYNC_BIT];
  assign burst_cfg.rdy_with_data = st_q.cfg_code[CFG_RDY_BIT];
  assign burst_cfg.rising_edge   = st_q.cfg_code[CFG_EDGE_BIT];
  assign burst_cfg.burst_len     = fbc_len_t'(st_q.cfg_code[CFG_LEN_LSB +: 2]);
  assign burst_cfg.init_cycles   = {1'b0, st_q.cfg_code[CFG_WAIT_LSB +: 3]} + WAIT_BASE;

  assign burst_enable = st_q.cfg_set & ~burst_cfg.async_mode;

  // A two-cycle access leaves no room to lead, so ready always rides with data then.
  // forced aligned ready
  assign early_rdy   = ~burst_cfg.rdy_with_data && (burst_cfg.init_cycles != WAIT_BASE);
  assign load_cycles = burst_cfg.init_cycles;

  // Config write is accepted only when no bank runs an embedded operation.
  // frozen while busy
  assign cfg_ok = ~any_busy;

  always_comb begin
    unique case (burst_cfg.burst_len)
      FBC_LEN_W8:  wmask = WRAP_MASK8;
      FBC_LEN_W16: wmask = WRAP_MASK16;
      FBC_LEN_W32: wmask = WRAP_MASK32;
      FBC_LEN_CONT: wmask = WRAP_MASKC;
    endcase
  end

  // Next-state logic for the whole front end.
  always_comb begin
    st_d          = st_q;
    st_d.we_s     = {st_q.we_s[1:0], ~write_strobe_n};
    st_d.avs_s    = {st_q.avs_s[1:0], address_valid_strobe_n};
    st_d.addr_s1  = addr_pin;
    st_d.addr_s2  = st_q.addr_s1;
    st_d.data_s1  = data_pin;
    st_d.data_s2  = st_q.data_s1;
    st_d.susp_req = '0;
    st_d.res_req  = '0;
    st_d.dvalid   = 1'b0;

    // Banks follow the algorithm engine; commands below may override.
    for (int i = 0; i < NBANK; i++) begin
      unique case (st_q.bank[i])
        FBC_BANK_READ: begin
          if (alg_busy[i]) begin
            st_d.bank[i] = FBC_BANK_BUSY;
          end
        end
        FBC_BANK_BUSY: begin
          if (!alg_busy[i]) begin
            st_d.bank[i] = FBC_BANK_READ;
          end
        end
        FBC_BANK_SUSP: begin
          if (alg_busy[i] && !st_q.susp_req[i]) begin
            st_d.bank[i] = FBC_BANK_SUSP_PROG;
          end
        end
        FBC_BANK_SUSP_PROG: begin
          if (!alg_busy[i]) begin
            st_d.bank[i] = FBC_BANK_SUSP;
          end
        end
        FBC_BANK_QUERY: begin
          st_d.bank[i] = FBC_BANK_QUERY;
        end
        default: begin
          st_d.bank[i] = FBC_BANK_READ;
        end
      endcase
    end

    // Command sequencer, one step per write cycle, taken when the write strobe falls.
    if (wr_evt) begin
      if (wdata == CMD_RESET) begin
        st_d.cmd = FBC_CMD_IDLE;
        if (cur_bank == FBC_BANK_QUERY) begin
          st_d.bank[bnk] = FBC_BANK_READ;
        end
      end else begin
        unique case (st_q.cmd)
          FBC_CMD_IDLE: begin
            if (wdata == CMD_UNLOCK1 && wlow == UNLOCK_ADDR1) begin
              st_d.cmd = FBC_CMD_UNL1;
            end else if (wdata == CMD_SUSPEND) begin
              if (cur_bank == FBC_BANK_BUSY && alg_erasing[bnk]) begin
                st_d.bank[bnk]     = FBC_BANK_SUSP;
                st_d.susp_sec[bnk] = sec;
                st_d.susp_req[bnk] = 1'b1;
              end
            end else if (wdata == CMD_RESUME) begin
              if (cur_bank == FBC_BANK_SUSP) begin
                st_d.bank[bnk]    = FBC_BANK_BUSY;
                st_d.res_req[bnk] = 1'b1;
              end
            end else begin
              st_d.cmd = FBC_CMD_ERROR;
            end
          end
          FBC_CMD_UNL1: begin
            if (wdata == CMD_UNLOCK2 && wlow == UNLOCK_ADDR2) begin
              st_d.cmd = FBC_CMD_UNL2;
            end else begin
              st_d.cmd = FBC_CMD_ERROR;
            end
          end
          FBC_CMD_UNL2: begin
            st_d.cmd = FBC_CMD_IDLE;
            if (wdata == CMD_CONFIG && wlow == UNLOCK_ADDR1) begin
              if (cfg_ok) begin
                st_d.cfg_code = st_q.addr_s2[CFG_MSB:CFG_LSB];
                st_d.cfg_set  = 1'b1;
              end
            end else if (wdata == CMD_QUERY && wlow == UNLOCK_ADDR1) begin
              st_d.bank[bnk] = FBC_BANK_QUERY;
            end else begin
              st_d.cmd = FBC_CMD_ERROR;
            end
          end
          FBC_CMD_ERROR: begin
            st_d.cmd = FBC_CMD_ERROR;
          end
          default: begin
            st_d.cmd = FBC_CMD_ERROR;
          end
        endcase
      end
    end

    // Burst timing: count initial cycles from the strobe, then stream words.
    if (avs_evt && burst_enable) begin
      st_d.bursting = 1'b1;
      st_d.cnt      = load_cycles;
      st_d.rdy      = 1'b0;
      st_d.bptr     = st_q.addr_s2;
    end else if (st_q.bursting) begin
      if (st_q.cnt != 4'h0) begin
        st_d.cnt = st_q.cnt - 4'h1;
        st_d.rdy = (st_q.cnt == 4'h2 && early_rdy) || (st_q.cnt == 4'h1);
        st_d.dvalid = (st_q.cnt == 4'h1);
      end else begin
        st_d.rdy    = 1'b1;
        st_d.dvalid = 1'b1;
        st_d.bptr = (st_q.bptr & ~wmask) | ((st_q.bptr + 21'h000001) & wmask);
      end
    end
    if (wr_evt || !burst_enable) begin
      st_d.bursting = 1'b0;
      st_d.rdy      = 1'b0;
      st_d.dvalid   = 1'b0;
    end
  end

  // The state register; defaults give array read and the reset configuration.
  // power-up read
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q          <= '0;
      st_q.we_s     <= 3'h0;
      st_q.avs_s    <= 3'h7;
      st_q.cmd      <= FBC_CMD_IDLE;
      st_q.bank     <= {NBANK{FBC_BANK_READ}};
      st_q.cfg_code <= CFG_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // A read is refused only in a busy bank or in the suspended sector.
  // other sectors readable
  assign read_allowed = (cur_bank == FBC_BANK_READ) || (cur_bank == FBC_BANK_QUERY) ||
                        (((cur_bank == FBC_BANK_SUSP) || (cur_bank == FBC_BANK_SUSP_PROG)) &&
                         (st_q.susp_sec[bnk] != sec));

  assign bank_mode   = st_q.bank;
  assign suspend_req = st_q.susp_req;
  assign resume_req  = st_q.res_req;
  assign cmd_error   = (st_q.cmd == FBC_CMD_ERROR);
  assign read_sector = sec;
  assign read_bank   = bnk;
  assign burst_addr  = st_q.bptr;
  assign ready_out   = st_q.rdy;
  assign data_valid  = st_q.dvalid;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_unlocked;
    wr_evt && st_q.cmd == FBC_CMD_UNL2;
  endsequence

  property p_cfg_commit;
    s_unlocked and (wdata == CMD_CONFIG && wlow == UNLOCK_ADDR1 && !any_busy) |=>
      st_q.cfg_code == $past(st_q.addr_s2[CFG_MSB:CFG_LSB]) && st_q.cfg_set;
  endproperty
  a_cfg_commit: assert property (p_cfg_commit) else $error("config code not latched");

  property p_cfg_stable;
    !(wr_evt && st_q.cmd == FBC_CMD_UNL2 && wdata == CMD_CONFIG && wlow == UNLOCK_ADDR1) |=>
      $stable(st_q.cfg_code);
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("config changed outside sequence");

  property p_cfg_busy;
    any_busy |=> $stable(st_q.cfg_code);
  endproperty
  a_cfg_busy: assert property (p_cfg_busy) else $error("config changed while busy");

  property p_no_burst_unset;
    !st_q.cfg_set |-> !st_q.bursting && !data_valid;
  endproperty
  a_no_burst_unset: assert property (p_no_burst_unset) else $error("burst before config");

  property p_error_sticky;
    cmd_error && !(wr_evt && wdata == CMD_RESET) |=> cmd_error;
  endproperty
  a_error_sticky: assert property (p_error_sticky) else $error("error left without reset");

  property p_done_read;
    st_q.bank[0] == FBC_BANK_BUSY && !alg_busy[0] && !wr_evt |=> st_q.bank[0] == FBC_BANK_READ;
  endproperty
  a_done_read: assert property (p_done_read) else $error("bank not back to read");

  sequence s_burst_start;
    avs_evt && burst_enable && !wr_evt;
  endsequence

  property p_two_cycle;
    (s_burst_start and burst_cfg.init_cycles == WAIT_BASE) ##1 (!wr_evt && burst_enable)
      |=> !ready_out ##1 (ready_out && data_valid);
  endproperty
  a_two_cycle: assert property (p_two_cycle) else $error("two-cycle access misaligned");

  property p_rdy_with;
    st_q.bursting && burst_cfg.rdy_with_data |-> ready_out == data_valid;
  endproperty
  a_rdy_with: assert property (p_rdy_with) else $error("ready not aligned with data");

  property p_first_data;
    (s_burst_start and burst_cfg.init_cycles == 4'h7) ##1 (!wr_evt && burst_enable)[*7]
      |=> data_valid && !$past(data_valid);
  endproperty
  a_first_data: assert property (p_first_data) else $error("first data not at seven cycles");

  property p_susp_read;
    cur_bank == FBC_BANK_SUSP && st_q.susp_sec[bnk] != sec |-> read_allowed;
  endproperty
  a_susp_read: assert property (p_susp_read) else $error("suspended bank read refused");

endmodule
`default_nettype wire

/* File: testbench/fbc_host_model.sv */
/*
  Host memory controller model: drives flash write cycles, the address bus and the burst strobe.
  Assumes a free-running sys_clk; the bench calls the tasks from one process only.
*/
`default_nettype none
module fbc_host_model
  import fbc_pkg::*;
(
  input  wire logic              sys_clk,
  output logic                   write_strobe_n,
  output logic      [ADDR_W-1:0] addr_pin,
  output logic      [DATA_W-1:0] data_pin,
  output logic                   address_valid_strobe_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // The bus idles with no write and no burst request.
  initial begin
    write_strobe_n         = 1'b1;
    addr_pin               = '0;
    data_pin               = 16'h0000;
    address_valid_strobe_n = 1'b1;
  end

  // Steps just past an edge so that no pin moves at a sampling edge.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  // one write cycle
  // Data is inverted after release, since an undriven bus would not keep its value.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    tick(1);
    addr_pin = a;
    data_pin = {8'h00, d};
    tick(4);
    write_strobe_n = 1'b0;
    tick(5);
    write_strobe_n = 1'b1;
    tick(6);
    data_pin = ~data_pin;
  endtask

  task automatic cfg(input logic [7:0] code);
    wr({9'h000, UNLOCK_ADDR1}, CMD_UNLOCK1);
    wr({9'h000, UNLOCK_ADDR2}, CMD_UNLOCK2);
    wr({1'b0, code, UNLOCK_ADDR1}, CMD_CONFIG);
  endtask

  task automatic reset_cmd(input logic [ADDR_W-1:0] a);
    wr(a, CMD_RESET);
  endtask

  // Address and burst strobe control.
  task automatic put(input logic [ADDR_W-1:0] a);
    tick(1);
    addr_pin = a;
  endtask

  task automatic avs_low(input logic [ADDR_W-1:0] a);
    tick(1);
    addr_pin = a;
    address_valid_strobe_n = 1'b0;
  endtask

  task automatic avs_high();
    tick(1);
    address_valid_strobe_n = 1'b1;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_fbc_cmd.sv */
/*
  Self-checking bench for the burst flash command front end with its own reference model.
  Assumes the host model drives the bus pins while the bench drives the bank status inputs.
*/
`default_nettype none
module tb_fbc_cmd
  import fbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                  sys_clk, arst_n, write_strobe_n, address_valid_strobe_n;
  logic                  burst_enable, cmd_error, read_allowed, ready_out, data_valid;
  logic      [ADDR_W-1:0] addr_pin, burst_addr;
  logic      [DATA_W-1:0] data_pin;
  logic      [NBANK-1:0] alg_busy, alg_erasing, suspend_req, resume_req;
  fbc_bank_t [NBANK-1:0] bank_mode;
  fbc_cfg_t              burst_cfg;
  logic      [SEC_W-1:0] read_sector;
  logic      [1:0]       read_bank;
  int                    fails, tests_run, cyc, n_sus, n_res, seed;
  int                    tbl[] = '{'h0, 'h1FFF, 'h2000, 'h7FFF, 'h8000, 'h7FFFF, 'h80000, 'hFFFFF,
                                   'h100000, 'h17FFFF, 'h180000, 'h1F7FFF, 'h1F8000, 'h1FFFFF};

  fbc_cmd fbc_cmd_i (.sys_clk, .arst_n, .write_strobe_n, .addr_pin, .data_pin, .address_valid_strobe_n,
    .alg_busy, .alg_erasing, .bank_mode, .suspend_req, .resume_req, .burst_cfg, .burst_enable,
    .cmd_error, .read_allowed, .read_sector, .read_bank, .burst_addr, .ready_out, .data_valid);
  fbc_host_model fbc_host_model_i (.sys_clk, .write_strobe_n, .addr_pin, .data_pin, .address_valid_strobe_n);

  // Free-running 100 MHz clock.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Pulse counters and the run limit; a hang is scored as a mismatch.
  always @(posedge sys_clk) begin
    cyc++;
    if (suspend_req[2] === 1'b1) n_sus++;
    if (resume_req[2] === 1'b1) n_res++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    $display("Summary: %0d mismatches in %0d checks", fails, tests_run);
    if (fails == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // Decoded configuration as the bit fields of the code say it should read.
  task automatic chk_cfg(input logic [7:0] c);
    fbc_cfg_t e;
    e = '{c[7], c[6], c[5], fbc_len_t'(c[4:3]), {1'b0, c[2:0]} + 4'h2};
    chk(32'(burst_cfg), 32'(e), "config");
  endtask

  // Reference sector map: 8K words at both ends, 32K words between.
  task automatic chk_dec(input int a);
    int s;
    fbc_host_model_i.put(21'(a));
    fbc_host_model_i.tick(3);
    s = (a < 'h8000) ? a / 'h2000 : (a >= 'h1F8000) ? 66 + (a - 'h1F8000) / 'h2000 : 3 + a / 'h8000;
    chk(read_sector, s, "sector");
    chk(read_bank, (s < 19) ? 0 : (s < 35) ? 1 : (s < 51) ? 2 : 3, "bank");
  endtask

  task automatic status(input int b, input logic busy, input logic erase, input int settle);
    fbc_host_model_i.tick(1);
    alg_busy[b] = busy;
    alg_erasing[b] = erase;
    fbc_host_model_i.tick(settle);
  endtask

  // Main sequence: reset, decode, command errors, busy refusal, suspend, then bursts.
  initial begin
    logic [7:0] c;
    logic [ADDR_W-1:0] st, m;
    int n, nr, w;
    seed = 67;
    fails = 0;
    tests_run = 0;
    cyc = 0;
    n_sus = 0;
    n_res = 0;
    arst_n = 1'b0;
    alg_busy = 4'h0;
    alg_erasing = 4'h0;
    repeat (6) @(posedge sys_clk);
    #1;
    arst_n = 1'b1;
    fbc_host_model_i.tick(6);
    chk_cfg(8'hE5);
    for (int b = 0; b < NBANK; b++) chk(bank_mode[b], FBC_BANK_READ, "mode");
    chk({burst_enable, cmd_error}, 0, "flags");
    foreach (tbl[i]) chk_dec(tbl[i]);
    repeat (12) chk_dec($random(seed) & 'h1FFFFF);
    fbc_host_model_i.avs_low(21'h000100);
    fbc_host_model_i.tick(15);
    chk({ready_out, data_valid}, 0, "burst off");
    fbc_host_model_i.avs_high();
    fbc_host_model_i.wr(21'h000555, CMD_UNLOCK1);
    fbc_host_model_i.wr(21'h000123, CMD_UNLOCK2);
    chk(cmd_error, 1, "bad unlock");
    fbc_host_model_i.wr(21'h000555, CMD_CONFIG);
    chk_cfg(8'hE5);
    fbc_host_model_i.reset_cmd(21'h0);
    chk(cmd_error, 0, "reset");
    fbc_host_model_i.wr(21'h000555, CMD_UNLOCK1);
    fbc_host_model_i.wr(21'h0002AA, CMD_UNLOCK2);
    fbc_host_model_i.wr(21'h012556, CMD_CONFIG);
    chk_cfg(8'hE5);
    fbc_host_model_i.reset_cmd(21'h0);
    fbc_host_model_i.wr(21'h000555, CMD_UNLOCK1);
    fbc_host_model_i.wr(21'h0002AA, CMD_UNLOCK2);
    fbc_host_model_i.wr(21'h1C0555, CMD_QUERY);
    chk(bank_mode[3], FBC_BANK_QUERY, "query");
    fbc_host_model_i.reset_cmd(21'h1C0000);
    chk(bank_mode[3], FBC_BANK_READ, "leave query");
    status(1, 1'b1, 1'b1, 2);
    chk(bank_mode[1], FBC_BANK_BUSY, "busy");
    fbc_host_model_i.cfg(8'h02);
    chk_cfg(8'hE5);
    status(1, 1'b0, 1'b0, 2);
    chk(bank_mode[1], FBC_BANK_READ, "done");
    status(2, 1'b1, 1'b1, 2);
    fbc_host_model_i.wr(21'h128000, CMD_SUSPEND);
    status(2, 1'b0, 1'b0, 2);
    chk(n_sus, 1, "suspend pulse");
    chk(bank_mode[2], FBC_BANK_SUSP, "suspended");
    status(2, 1'b1, 1'b0, 2);
    status(2, 1'b0, 1'b0, 2);
    chk_dec('h130000);
    chk(read_allowed, 1, "other sector");
    chk_dec('h128000);
    chk(read_allowed, 0, "suspended sector");
    fbc_host_model_i.wr(21'h128000, CMD_RESUME);
    chk(n_res, 1, "resume pulse");
    status(2, 1'b1, 1'b1, 4);
    status(2, 1'b0, 1'b0, 2);
    chk(bank_mode[2], FBC_BANK_READ, "erase done");
    // The two end banks run an algorithm too, so every status input bit is exercised.
    for (int b = 0; b < NBANK; b += 3) begin
      status(b, 1'b1, 1'b1, 2);
      chk(bank_mode[b], FBC_BANK_BUSY, "end bank busy");
      status(b, 1'b0, 1'b0, 2);
      chk(bank_mode[b], FBC_BANK_READ, "end bank done");
    end
    for (int i = 0; i < 8; i++) begin
      w = i % 6;
      c = {1'b0, 1'(i), 1'($random(seed)), 2'(i >> 1), 3'(w)};
      st = (i == 0) ? 21'h1FFFFA : 21'($random(seed)) & 21'h1FFFFE;
      m = (i < 2) ? 21'h1FFFFF : 21'((8 << ((i >> 1) - 1)) - 1);
      fbc_host_model_i.cfg(c);
      chk_cfg(c);
      chk(burst_enable, 1, "enable");
      fbc_host_model_i.avs_low(st);
      n = 0;
      nr = 0;
      while (data_valid !== 1'b1 && n < 20) begin
        fbc_host_model_i.tick(1);
        n++;
        if (ready_out === 1'b1 && nr == 0) nr = n;
      end
      // Initial access is the wait code plus two, behind two sync stages and the edge detect.
      chk(n, w + 5, "latency");
      chk(nr, (i[0] == 1'b0 && w > 0) ? w + 4 : w + 5, "ready");
      for (int k = 0; k < 40; k++) begin
        chk(burst_addr, (st & ~m) | ((st + k) & m), "pointer");
        fbc_host_model_i.tick(1);
      end
      fbc_host_model_i.avs_high();
    end
    fbc_host_model_i.cfg(8'hE5);
    chk(burst_enable, 0, "async");
    close_out();
  end
endmodule
`default_nettype wire
